// [rfap_once_field.sv]
`timescale 1ns/1ps
`default_nettype none
module rfap_once_field
    import rfap_pkg::*;
#(
    parameter int          W   = 16,
    parameter logic [15:0] DEF = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         pg_rst_n,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] value,
    output logic              written
);
    // Value and flag on power-good only
    always_ff @(posedge clk or negedge pg_rst_n) begin
        if (!pg_rst_n) begin
            value   <= DEF[W-1:0];
            written <= 1'b0;
        end else if (wr && !written) begin
            value   <= wdata;
            written <= 1'b1;
        end
    end

    a_once_holds: assert property (@(posedge clk) disable iff (!pg_rst_n)
        written |=> $stable(value) && written)
        else $error("write-once field changed after first write");
endmodule : rfap_once_field
`default_nettype wire

// [rfap_pkg.sv]
package rfap_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ONCE    = 8'h00;
    localparam logic [7:0] ADDR_VOLROD  = 8'h04;
    localparam logic [7:0] ADDR_STKVOL  = 8'h08;
    localparam logic [7:0] ADDR_LOCKCTL = 8'h0C;
    localparam logic [7:0] ADDR_STKLCK  = 8'h10;
    localparam logic [7:0] ADDR_STKLCKV = 8'h14;
    localparam logic [7:0] ADDR_MRO     = 8'h18;
    localparam logic [7:0] ADDR_RAWM    = 8'h1C;
    localparam logic [7:0] ADDR_MRW     = 8'h20;
    localparam logic [7:0] ADDR_MW1C    = 8'h24;
    localparam logic [7:0] ADDR_MODE    = 8'h28;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h2C;
    localparam logic [7:0] ADDR_IRQMASK = 8'h30;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int          FIELD_W      = 16;
    localparam logic [15:0] FIELD_MASK   = 16'hFFFF;
    localparam logic [31:0] RESERVED_PROTECTED_MASK  = 32'hFF00_0000;
    localparam logic [15:0] DEF_ONCE     = 16'h0000;
    localparam logic [15:0] DEF_STKVOL   = 16'h0000;
    localparam logic [15:0] DEF_STKLCK   = 16'h0000;
    localparam logic [15:0] DEF_MGMT     = 16'h0000;
    localparam int          LOCK_BIT     = 0;
    localparam int          LOCK_V_BIT   = 1;
    localparam int          MODE_BIT     = 0;
    localparam int          IRQ_W        = 2;
    localparam int          IRQ_GPF      = 0;
    localparam int          IRQ_HWUPD    = 1;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Hardware update port of one volatile field
    typedef struct packed {
        logic        upd;
        logic [15:0] val;
    } rfap_hwupd_s;

    // One decoded software access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rfap_acc_s;

endpackage : rfap_pkg

// [rfap_sticky_field.sv]
`timescale 1ns/1ps
`default_nettype none
module rfap_sticky_field
    import rfap_pkg::*;
#(
    parameter int          W   = 16,
    parameter logic [15:0] DEF = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         pg_rst_n,
    input  wire logic         sw_wr,
    input  wire logic         locked,
    input  wire logic [W-1:0] sw_data,
    input  wire logic         hw_upd,
    input  wire logic [W-1:0] hw_data,
    output logic      [W-1:0] value
);
    wire sw_take = sw_wr && !locked;

    always_ff @(posedge clk or negedge pg_rst_n) begin
        if (!pg_rst_n) begin
            value <= DEF[W-1:0];
        end else if (hw_upd) begin
            value <= hw_data;
        end else if (sw_take) begin
            value <= sw_data;
        end
    end

    a_lock_blocks_sw: assert property (@(posedge clk) disable iff (!pg_rst_n)
        locked && !hw_upd |=> $stable(value))
        else $error("locked field changed by software");
endmodule : rfap_sticky_field
`default_nettype wire

// [rfap_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Sticky write-once value and flag reset only by power-good reset.
// - Hardware may update volatile fields at any time.
// - Sticky volatile field: sw and hw access, reset only by power-good.
// - Sticky lockable: value sticky, lock follows its own control field.
// - Mgmt-only read: read in mode, writes ignored; outside raises fault.
// - Read anywhere, write only in mode; outside write raises fault.
// - Mgmt-only read-write; write outside mode raises fault.
// - Mgmt write-one-clear: one clears, zero keeps, only in mode.
// - Don't-care reserved bits ignore writes.
// - Write-once field takes one write then is read-only.
// - Lockable fields read-only while lock is set.
module rfap_top
    import rfap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pg_rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire rfap_hwupd_s hw_volrod,
    input  wire rfap_hwupd_s hw_stkvol,
    input  wire rfap_hwupd_s hw_stklckv,
    input  wire logic [15:0] hw_mw1c_set,
    output logic             general_protection_fault,
    output logic             irq
);
    // ----------------------------------------------------------------
    // Bus capture
    // ----------------------------------------------------------------
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire do_wr = aw_full && w_full && !s_axi_bvalid;
    wire do_rd = s_axi_arvalid && s_axi_arready;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (do_wr) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (do_wr) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Slot flags mirror the ready flops, so the ready ports are registered
    assign aw_full = !s_axi_awready;
    assign w_full  = !s_axi_wready;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic        in_mode;
    logic [1:0]  lock_ctl;
    logic [15:0] volrod;
    logic [15:0] mro;
    logic [15:0] rawm;
    logic [15:0] mrw;
    logic [15:0] mw1c;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] once_val;
    logic        once_done;
    logic [15:0] stkvol;
    logic [15:0] stklck;
    logic [15:0] stklckv;

    // Write data with unstrobed bytes forced to zero
    wire [31:0] wd    = w_data & wmask;
    wire [15:0] wfld  = wd[15:0];
    wire w_once   = do_wr && aw_addr == ADDR_ONCE;
    wire w_stkvol = do_wr && aw_addr == ADDR_STKVOL;
    wire w_lock   = do_wr && aw_addr == ADDR_LOCKCTL;
    wire w_stklck = do_wr && aw_addr == ADDR_STKLCK;
    wire w_stklcv = do_wr && aw_addr == ADDR_STKLCKV;
    wire w_mro    = do_wr && aw_addr == ADDR_MRO;
    wire w_rawm   = do_wr && aw_addr == ADDR_RAWM;
    wire w_mrw    = do_wr && aw_addr == ADDR_MRW;
    wire w_mw1c   = do_wr && aw_addr == ADDR_MW1C;
    wire w_mode   = do_wr && aw_addr == ADDR_MODE;
    wire w_istat  = do_wr && aw_addr == ADDR_IRQSTAT;
    wire w_imask  = do_wr && aw_addr == ADDR_IRQMASK;
    wire w_known  = w_once | w_stkvol | w_lock | w_stklck | w_stklcv | w_mro | w_rawm
                  | w_mrw | w_mw1c | w_mode | w_istat | w_imask
                  | (do_wr && aw_addr == ADDR_VOLROD);

    wire r_mro    = do_rd && s_axi_araddr == ADDR_MRO;
    wire r_mrw    = do_rd && s_axi_araddr == ADDR_MRW;
    wire r_mw1c   = do_rd && s_axi_araddr == ADDR_MW1C;

    // Outside the mode, any MRO access and RAWM or MRW writes fault
    wire gpf_mro  = !in_mode && (w_mro || r_mro);
    wire gpf_rawm = !in_mode && w_rawm;
    wire gpf_mrw  = !in_mode && w_mrw;
    wire gpf_evt  = gpf_mro | gpf_rawm | gpf_mrw;
    wire hw_evt   = hw_volrod.upd | hw_stkvol.upd | hw_stklckv.upd;

    // ----------------------------------------------------------------
    // Sticky and write-once fields
    // ----------------------------------------------------------------
    rfap_once_field #(.W(FIELD_W), .DEF(DEF_ONCE)) u_once (
        .clk     (clk),
        .pg_rst_n(pg_rst_n),
        .wr      (w_once),
        .wdata   (wfld),
        .value   (once_val),
        .written (once_done)
    );

    rfap_sticky_field #(.W(FIELD_W), .DEF(DEF_STKVOL)) u_stkvol (
        .clk     (clk),
        .pg_rst_n(pg_rst_n),
        .sw_wr   (w_stkvol),
        .locked  (1'b0),
        .sw_data (wfld),
        .hw_upd  (hw_stkvol.upd),
        .hw_data (hw_stkvol.val),
        .value   (stkvol)
    );

    // Value sticky, lock lives in ordinary-reset control
    rfap_sticky_field #(.W(FIELD_W), .DEF(DEF_STKLCK)) u_stklck (
        .clk     (clk),
        .pg_rst_n(pg_rst_n),
        .sw_wr   (w_stklck),
        .locked  (lock_ctl[LOCK_BIT]),
        .sw_data (wfld),
        .hw_upd  (1'b0),
        .hw_data (DEF_STKLCK),
        .value   (stklck)
    );

    rfap_sticky_field #(.W(FIELD_W), .DEF(DEF_STKLCK)) u_stklckv (
        .clk     (clk),
        .pg_rst_n(pg_rst_n),
        .sw_wr   (w_stklcv),
        .locked  (lock_ctl[LOCK_V_BIT]),
        .sw_data (wfld),
        .hw_upd  (hw_stklckv.upd),
        .hw_data (hw_stklckv.val),
        .value   (stklckv)
    );

    // ----------------------------------------------------------------
    // Ordinary-reset fields
    // ----------------------------------------------------------------
    // Lock is volatile across ordinary reset; software must relock after it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_ctl <= 2'h0;
            in_mode  <= 1'b0;
            volrod   <= 16'h0000;
            mro      <= DEF_MGMT;
            rawm     <= DEF_MGMT;
            mrw      <= DEF_MGMT;
        end else begin
            if (w_lock) begin
                lock_ctl <= wd[1:0];
            end
            if (w_mode) begin
                in_mode <= wd[MODE_BIT];
            end
            if (hw_volrod.upd) begin
                volrod <= hw_volrod.val;
            end
            if (w_rawm && in_mode) begin
                rawm <= wfld;
            end
            if (w_mrw && in_mode) begin
                mrw <= wfld;
            end
        end
    end

    // Clear by one in mode, hardware set wins
    wire [15:0] mw1c_clr = (w_mw1c && in_mode) ? wfld : 16'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mw1c <= DEF_MGMT;
        end else begin
            // Outside mode the clear mask is zero
            mw1c <= (mw1c & ~mw1c_clr) | hw_mw1c_set;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    wire [IRQ_W-1:0] irq_set = {hw_evt, gpf_evt};
    wire [IRQ_W-1:0] irq_clr = w_istat ? wd[IRQ_W-1:0] : '0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
            general_protection_fault <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            if (w_imask) begin
                irq_mask <= wd[IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
            general_protection_fault <= gpf_evt;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and responses
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_ok;
    wire  [7:0]  ra = s_axi_araddr;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        // Reserved upper bits read zero, writes dropped
        unique case (ra)
            ADDR_ONCE:    rd_mux = {15'h0000, once_done, once_val};
            ADDR_VOLROD:  rd_mux = {16'h0000, volrod};
            ADDR_STKVOL:  rd_mux = {16'h0000, stkvol};
            ADDR_LOCKCTL: rd_mux = {30'h0000_0000, lock_ctl};
            ADDR_STKLCK:  rd_mux = {16'h0000, stklck};
            ADDR_STKLCKV: rd_mux = {16'h0000, stklckv};
            ADDR_MRO:     rd_mux = in_mode ? {16'h0000, mro} : 32'h0000_0000;
            ADDR_RAWM:    rd_mux = {16'h0000, rawm};
            ADDR_MRW:     rd_mux = in_mode ? {16'h0000, mrw} : 32'h0000_0000;
            ADDR_MW1C:    rd_mux = in_mode ? {16'h0000, mw1c} : 32'h0000_0000;
            ADDR_MODE:    rd_mux = {31'h0000_0000, in_mode};
            ADDR_IRQSTAT: rd_mux = {30'h0000_0000, irq_stat};
            ADDR_IRQMASK: rd_mux = {30'h0000_0000, irq_mask};
            default:      rd_ok  = 1'b0;
        endcase
    end
    wire rd_err = !rd_ok || r_mro || (!in_mode && (r_mrw || r_mw1c));
    wire wr_err = !w_known || gpf_evt;

    // Read ready is the registered inverse of rvalid: one read in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (do_rd) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (rd_err && (!in_mode || !rd_ok)) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mgmt_rw_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (do_wr && aw_addr == ADDR_MRW && !in_mode) |=> general_protection_fault && $stable(mrw))
        else $error("write outside mode did not fault");
    a_rawm_write_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (w_rawm && !in_mode) |=> $stable(rawm) ##1 s_axi_bresp == RESP_SLVERR)
        else $error("read-any field written outside mode");
    a_mro_read_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (do_rd && ra == ADDR_MRO && !in_mode) |=> general_protection_fault && s_axi_rdata == 32'h0)
        else $error("mgmt-only read outside mode not faulted");
    a_w1c_outside: assert property (@(posedge clk) disable iff (!rst_n)
        (w_mw1c && !in_mode) |=> (mw1c & $past(mw1c)) == $past(mw1c))
        else $error("clear happened outside mode");
    a_w1c_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (w_mw1c && in_mode && hw_mw1c_set == 16'h0) |=> (mw1c & $past(wfld)) == 16'h0)
        else $error("write one did not clear");
    a_volrod_upd: assert property (@(posedge clk) disable iff (!rst_n)
        hw_volrod.upd |=> volrod == $past(hw_volrod.val))
        else $error("hardware update lost");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        |(irq_stat & irq_mask) |=> irq)
        else $error("interrupt not raised");
endmodule : rfap_top
`default_nettype wire

// [tb_register_field_access_policies.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_register_field_access_policies
    import rfap_pkg::*;
;
    localparam logic [2:0] OK   = {1'b0, RESP_OKAY};
    localparam logic [2:0] ERR  = {1'b0, RESP_SLVERR};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pg_rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [3:0]  strb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, gpf, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    rfap_hwupd_s hwv [3] = '{default: '0};
    logic [15:0] mset = 16'h0;
    logic [31:0] rnd = 32'h7C31C880;
    logic [31:0] d, d2;
    logic [65:0] er;
    logic [2:0]  eb;
    logic [2:0]  exp_b[$];
    logic [65:0] exp_r[$];
    int          failures = 0, n_compared = 0, n_fault = 0, f0 = 0, n;

    always #2.5 clk = ~clk;

    rfap_top rfap_top_inst (
        .clk(clk), .rst_n(rst_n), .pg_rst_n(pg_rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_volrod(hwv[0]), .hw_stkvol(hwv[1]), .hw_stklckv(hwv[2]), .hw_mw1c_set(mset),
        .general_protection_fault(gpf), .irq(irq)
    );

    function logic [31:0] rand32();
        rnd = {rnd[30:0], ^(rnd & 32'h8020_0003)};
        return rnd;
    endfunction : rand32

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // --------------------------------------------------------------
    // Response watcher: each answer is matched to the oldest note
    // --------------------------------------------------------------
    always @(posedge clk) begin
        if (gpf === 1'b1) n_fault++;
        if (bvalid === 1'b1 && bready) begin
            if (exp_b.size() == 0) failures++;
            else begin
                eb = exp_b.pop_front();
                check({30'h0, bresp}, {30'h0, eb[1:0]});
            end
        end
        if (rvalid === 1'b1 && rready) begin
            if (exp_r.size() == 0) failures++;
            else begin
                er = exp_r.pop_front();
                check(rdata & er[63:32], er[31:0]);
                check({30'h0, rresp}, {30'h0, er[65:64]});
            end
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] dv, input logic [2:0] r);
        @(posedge clk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= dv;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) bready <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        if (n >= 200) failures++;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] dv, input logic [31:0] m, input logic [2:0] r);
        @(posedge clk);
        exp_r.push_back({r[1:0], m, dv});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) rready <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        if (n >= 200) failures++;
    endtask : rd

    task wro(input logic [7:0] a, input logic [31:0] dv);
        wr(a, dv, OK);
    endtask : wro

    task rdo(input logic [7:0] a, input logic [31:0] dv);
        rd(a, dv, 32'hFFFF_FFFF, OK);
    endtask : rdo

    task hw(input int k, input logic [15:0] v);
        @(posedge clk);
        hwv[k] <= {1'b1, v};
        @(posedge clk);
        hwv[k] <= '0;
    endtask : hw

    // Pulse one of the two resets in mid-run
    task rr(input bit pg);
        @(posedge clk);
        if (pg) pg_rst_n <= 1'b0;
        else rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        pg_rst_n <= 1'b1;
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : rr

    task fchk(input int e);
        repeat (3) @(posedge clk);
        check(32'(n_fault - f0), 32'(e));
    endtask : fchk

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        #100000;
        failures++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        pg_rst_n <= 1'b1;
        // --------------------------------------------------------------
        // Write-once field
        // --------------------------------------------------------------
        d = rand32();
        d2 = rand32();
        wro(ADDR_ONCE, d);
        wro(ADDR_ONCE, ~d);
        rdo(ADDR_ONCE, {15'h0, 1'b1, d[15:0]});
        rr(0);
        rdo(ADDR_ONCE, {15'h0, 1'b1, d[15:0]});
        rr(1);
        rdo(ADDR_ONCE, 32'h0);
        wro(ADDR_ONCE, d2);
        rdo(ADDR_ONCE, {15'h0, 1'b1, d2[15:0]});
        $display("test once done");
        // --------------------------------------------------------------
        // Volatile and sticky volatile fields
        // --------------------------------------------------------------
        wro(ADDR_STKVOL, d);
        rdo(ADDR_STKVOL, {16'h0, d[15:0]});
        hw(1, d2[15:0]);
        rdo(ADDR_STKVOL, {16'h0, d2[15:0]});
        rr(0);
        rdo(ADDR_STKVOL, {16'h0, d2[15:0]});
        rr(1);
        rdo(ADDR_STKVOL, 32'h0);
        hw(0, d[31:16]);
        wro(ADDR_VOLROD, d2);
        rdo(ADDR_VOLROD, {16'h0, d[31:16]});
        $display("test volatile done");
        // --------------------------------------------------------------
        // Lockable sticky fields
        // --------------------------------------------------------------
        wro(ADDR_STKLCK, d);
        wro(ADDR_LOCKCTL, 32'h3);
        wro(ADDR_STKLCK, ~d);
        rdo(ADDR_STKLCK, {16'h0, d[15:0]});
        hw(2, d2[31:16]);
        rdo(ADDR_STKLCKV, {16'h0, d2[31:16]});
        rr(0);
        rdo(ADDR_LOCKCTL, 32'h0);
        rdo(ADDR_STKLCK, {16'h0, d[15:0]});
        wro(ADDR_STKLCK, ~d);
        rdo(ADDR_STKLCK, {16'h0, ~d[15:0]});
        $display("test lock done");
        // --------------------------------------------------------------
        // Management-mode fields, outside and inside the mode
        // --------------------------------------------------------------
        f0 = n_fault;
        rd(ADDR_MRO, 32'h0, 32'hFFFF_FFFF, ERR);
        wr(ADDR_MRO, d, ERR);
        rdo(ADDR_RAWM, 32'h0);
        wr(ADDR_RAWM, d, ERR);
        wr(ADDR_MRW, d, ERR);
        rd(ADDR_MRW, 32'h0, 32'hFFFF_FFFF, ERR);
        fchk(4);
        // Enter the mode, then write and read each field again
        wro(ADDR_MODE, 32'h1);
        wro(ADDR_MRO, d);
        rdo(ADDR_MRO, 32'h0);
        wro(ADDR_RAWM, d);
        rdo(ADDR_RAWM, {16'h0, d[15:0]});
        wro(ADDR_MRW, d2);
        rdo(ADDR_MRW, {16'h0, d2[15:0]});
        fchk(4);
        @(posedge clk);
        mset <= 16'hF0F0;
        @(posedge clk);
        mset <= 16'h0;
        rdo(ADDR_MW1C, 32'h0000_F0F0);
        wro(ADDR_MW1C, 32'hFFFF_00F0);
        rdo(ADDR_MW1C, 32'h0000_F000);
        wro(ADDR_MODE, 32'h0);
        wr(ADDR_MW1C, 32'h0000_F000, OK);
        wro(ADDR_MODE, 32'h1);
        rdo(ADDR_MW1C, 32'h0000_F000);
        strb = 4'h1;
        wro(ADDR_MRW, 32'hFFFF_FFA5);
        strb = 4'hF;
        rdo(ADDR_MRW, 32'h0000_00A5);
        wr(8'h3C, d, ERR);
        rd(8'h3C, 32'h0, 32'h0, ERR);
        $display("test mode done");
        // --------------------------------------------------------------
        // Interrupt status, mask and output
        // --------------------------------------------------------------
        wro(ADDR_IRQSTAT, 32'h3);
        rdo(ADDR_IRQSTAT, 32'h0);
        wro(ADDR_IRQMASK, 32'h1);
        wro(ADDR_MODE, 32'h0);
        wr(ADDR_MRW, d, ERR);
        fchk(5);
        check({31'h0, irq}, 32'h1);
        rdo(ADDR_IRQSTAT, 32'h1);
        hw(0, d2[15:0]);
        wro(ADDR_IRQSTAT, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rdo(ADDR_IRQSTAT, 32'h2);
        wro(ADDR_IRQMASK, 32'h3);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wro(ADDR_IRQSTAT, 32'h2);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        $display("test irq done");
        repeat (5) @(posedge clk);
        if (exp_b.size() != 0 || exp_r.size() != 0) failures++;
        summarize();
    end
endmodule : tb_register_field_access_policies
`default_nettype wire
